// ---- hdl/sih_pkg.sv ----
// constants, types and pin bundle for the serial interrupt host controller
package sih_pkg;

    // cycle shape
    localparam int unsigned FRAME_COUNT    = 17;
    localparam int unsigned IRQ_COUNT      = 16;
    localparam int unsigned START_MIN_W    = 4;
    localparam int unsigned START_MAX_W    = 8;
    localparam int unsigned STOP_QUIET_W   = 2;
    localparam int unsigned STOP_CONT_W    = 3;
    localparam int unsigned DATA_CLOCKS    = 3 * FRAME_COUNT + 1;
    localparam int unsigned LATENCY_MAX    = 96;

    // clock
    localparam real         CLK_PERIOD_NS  = 100.0;

    // reset values
    localparam logic        QUIET_RESET    = 1'b0;
    localparam logic [15:0] IRQ_RESET      = 16'hFFFF;

    // phase of a data frame
    localparam logic [1:0]  PH_SAMPLE      = 2'h0;
    localparam logic [1:0]  PH_RECOVER     = 2'h1;
    localparam logic [1:0]  PH_TURN        = 2'h2;

    typedef enum logic [6:0] {
        ST_IDLE       = 7'h01,
        ST_START_LOW  = 7'h02,
        ST_START_HIGH = 7'h04,
        ST_DATA       = 7'h08,
        ST_STOP_LOW   = 7'h10,
        ST_STOP_HIGH  = 7'h20,
        ST_GAP        = 7'h40
    } sih_state_t;

    // drive side of the shared interrupt wire
    typedef struct packed {
        logic oe;
        logic out;
    } sih_drive_t;

endpackage : sih_pkg

// ---- hdl/sih_host.sv ----
// host controller for the single-wire serialized interrupt bus
//
// Operation
// - no start frame while a cycle runs; bus idle only between stop and start.
// - host holds start low so the total pulse is 4 to 8 clocks, then one high.
// - in continuous mode only the host starts frames, optionally back to back.
// - mode changes only in stop frame; its width sets the next mode.
// - stop low 2 clocks means quiet mode, 3 clocks means continuous mode.
// - next start no earlier than second clock after stop rising edge.
// - only the host ends a cycle, with a 2 or 3 clock stop frame.
// - delivery latency may reach 96 clocks with seventeen frames.
// - hold end-of-interrupt and in-service reads behind the cycle latency; only eoi_grant is held here, until idle with no start pending.
// - drive and sample the line only on the rising clock edge.
// - line tri-stated in reset; continuous mode after reset.
// - host runs a first cycle after reset to collect default levels.
`timescale 1ns/1ps

module sih_host (
    // clock, reset, enable
    input  wire logic               ref_clk,
    input  wire logic               reset,
    input  wire logic               ce,
    // shared interrupt wire
    input  wire logic               serial_interrupt_line,
    output sih_pkg::sih_drive_t     line_drv,
    // host controls
    input  wire logic               start_req,
    input  wire logic               run_continuous,
    input  wire logic               quiet_sel,
    input  wire logic [3:0]         start_width,
    // collected levels and status
    output logic [15:0]             irq_level,
    output logic                    quiet_mode,
    output logic                    cycle_active,
    output logic                    cycle_done,
    // end-of-interrupt gating
    input  wire logic               eoi_req,
    output logic                    eoi_grant
);

    sih_pkg::sih_state_t state;
    logic [3:0]          cnt;
    logic [3:0]          stop_w;
    logic [1:0]          phase;
    logic [4:0]          fidx;
    logic                start_pending;
    logic                dev_start;
    logic                host_start;
    logic [3:0]          start_w;
    logic [3:0]          hlow;

    // width outside the legal span is clamped rather than trusted
    function automatic logic [3:0] clamp_width(input logic [3:0] w);
        if (w < 4'(sih_pkg::START_MIN_W)) begin
            clamp_width = 4'(sih_pkg::START_MIN_W);
        end else if (w > 4'(sih_pkg::START_MAX_W)) begin
            clamp_width = 4'(sih_pkg::START_MAX_W);
        end else begin
            clamp_width = w;
        end
    endfunction : clamp_width

    assign start_w = clamp_width(start_width);

    // a low line while idle in quiet mode is a device start pulse
    assign dev_start  = (state == sih_pkg::ST_IDLE) && quiet_mode
                        && !serial_interrupt_line;
    assign host_start = (state == sih_pkg::ST_IDLE) && !dev_start
                        && (start_pending || run_continuous);

    // sequencer
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= sih_pkg::ST_IDLE;
            cnt   <= 4'h0;
            phase <= 2'h0;
            fidx  <= 5'h00;
        end else if (ce) begin
            case (state)
                sih_pkg::ST_IDLE: begin
                    if (dev_start) begin
                        state <= sih_pkg::ST_START_LOW;
                        cnt   <= 4'h1;
                    end else if (host_start) begin
                        state <= sih_pkg::ST_START_LOW;
                        cnt   <= 4'h0;
                    end
                end
                sih_pkg::ST_START_LOW: begin
                    if (cnt + 4'h1 >= start_w) begin
                        state <= sih_pkg::ST_START_HIGH;
                    end
                    cnt <= cnt + 4'h1;
                end
                sih_pkg::ST_START_HIGH: begin
                    state <= sih_pkg::ST_DATA;
                    phase <= sih_pkg::PH_TURN;
                    fidx  <= 5'h00;
                end
                sih_pkg::ST_DATA: begin
                    case (phase)
                        sih_pkg::PH_TURN: begin
                            if (fidx == 5'(sih_pkg::FRAME_COUNT)) begin
                                state <= sih_pkg::ST_STOP_LOW;
                                cnt   <= 4'h0;
                            end
                            phase <= sih_pkg::PH_SAMPLE;
                        end
                        sih_pkg::PH_SAMPLE: begin
                            phase <= sih_pkg::PH_RECOVER;
                            fidx  <= fidx + 5'h01;
                        end
                        default: begin
                            phase <= sih_pkg::PH_TURN;
                        end
                    endcase
                end
                sih_pkg::ST_STOP_LOW: begin
                    if (cnt + 4'h1 >= stop_w) begin
                        state <= sih_pkg::ST_STOP_HIGH;
                    end
                    cnt <= cnt + 4'h1;
                end
                sih_pkg::ST_STOP_HIGH: begin
                    state <= sih_pkg::ST_GAP;
                end
                sih_pkg::ST_GAP: begin
                    state <= sih_pkg::ST_IDLE;
                end
                default: begin
                    state <= sih_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // stop width chosen as the stop frame begins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stop_w <= 4'(sih_pkg::STOP_CONT_W);
        end else if (ce && state == sih_pkg::ST_DATA && phase == sih_pkg::PH_TURN
                     && fidx == 5'(sih_pkg::FRAME_COUNT)) begin
            stop_w <= quiet_sel ? 4'(sih_pkg::STOP_QUIET_W)
                                : 4'(sih_pkg::STOP_CONT_W);
        end
    end

    // mode switches only as the stop pulse ends
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            quiet_mode <= sih_pkg::QUIET_RESET;
        end else if (ce && state == sih_pkg::ST_STOP_LOW && cnt + 4'h1 >= stop_w) begin
            quiet_mode <= (stop_w == 4'(sih_pkg::STOP_QUIET_W));
        end
    end

    // pending host start; first cycle after reset is forced, new request beats take
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            start_pending <= 1'b1;
        end else if (ce) begin
            start_pending <= (start_pending && !(host_start || dev_start)) || start_req;
        end
    end

    // sample clock of frame N is 3N-1 after the start rising edge
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_level <= sih_pkg::IRQ_RESET;
        end else if (ce && state == sih_pkg::ST_DATA && phase == sih_pkg::PH_SAMPLE
                     && fidx < 5'(sih_pkg::IRQ_COUNT)) begin
            irq_level[fidx[3:0]] <= serial_interrupt_line;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cycle_done <= 1'b0;
        end else if (ce) begin
            cycle_done <= (state == sih_pkg::ST_STOP_HIGH);
        end
    end

    // helper: consecutive clocks the host has driven low
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hlow <= 4'h0;
        end else if (ce) begin
            hlow <= (line_drv.oe && !line_drv.out) ? hlow + 4'h1 : 4'h0;
        end
    end

    // line drive; released in reset, idle, data and gap
    always_comb begin
        line_drv.oe  = 1'b0;
        line_drv.out = 1'b1;
        case (state)
            sih_pkg::ST_START_LOW, sih_pkg::ST_STOP_LOW: begin
                line_drv.oe  = !reset;
                line_drv.out = 1'b0;
            end
            sih_pkg::ST_START_HIGH, sih_pkg::ST_STOP_HIGH: begin
                line_drv.oe  = !reset;
                line_drv.out = 1'b1;
            end
            default: begin
                line_drv.oe  = 1'b0;
                line_drv.out = 1'b1;
            end
        endcase
    end

    assign cycle_active = (state != sih_pkg::ST_IDLE) && (state != sih_pkg::ST_GAP);
    // eoi held until the bus is quiet so it cannot pass a pending change
    assign eoi_grant = eoi_req && (state == sih_pkg::ST_IDLE) && !start_pending
                       && !dev_start;

    a_reset_release: assert property (
        @(posedge ref_clk) disable iff (reset) $past(reset) |-> !line_drv.oe)
        else $error("line driven right after reset");

    a_start_width: assert property (
        @(posedge ref_clk) disable iff (reset || !ce)
        (state == sih_pkg::ST_START_HIGH) |-> (hlow >= 4'h3 && hlow <= 4'h8))
        else $error("start pulse width out of range");

    a_start_high_one: assert property (
        @(posedge ref_clk) disable iff (reset || !ce)
        (state == sih_pkg::ST_START_HIGH) |-> line_drv.oe && line_drv.out
        ##1 !line_drv.oe)
        else $error("start pulse not ended by one high clock");

    a_data_released: assert property (
        @(posedge ref_clk) disable iff (reset || !ce)
        (state == sih_pkg::ST_DATA) |-> !line_drv.oe)
        else $error("host drove the line in a data frame");

    a_cycle_length: assert property (
        @(posedge ref_clk) disable iff (reset || !ce)
        (state == sih_pkg::ST_START_HIGH) |-> ##53 (state == sih_pkg::ST_STOP_LOW))
        else $error("stop frame not after seventeen frames");

    a_stop_width: assert property (
        @(posedge ref_clk) disable iff (reset || !ce)
        (state == sih_pkg::ST_STOP_HIGH) |-> (hlow == stop_w)
        && (hlow == 4'h2 || hlow == 4'h3))
        else $error("stop pulse width wrong");

    a_mode_from_stop: assert property (
        @(posedge ref_clk) disable iff (reset || !ce)
        $rose(cycle_done) |-> quiet_mode == (stop_w == 4'h2))
        else $error("mode does not follow stop width");

    a_gap_spacing: assert property (
        @(posedge ref_clk) disable iff (reset || !ce)
        (state == sih_pkg::ST_STOP_HIGH) |=> (state == sih_pkg::ST_GAP) && !line_drv.oe)
        else $error("start allowed too early after stop");

    a_no_start_active: assert property (
        @(posedge ref_clk) disable iff (reset || !ce)
        (state == sih_pkg::ST_DATA) |=> (state != sih_pkg::ST_START_LOW))
        else $error("start frame inside an active cycle");

    a_reset_drive: assert property (
        @(posedge ref_clk) reset |-> !line_drv.oe)
        else $error("line driven while in reset");

    // first ce edge out of reset must launch the collecting cycle
    a_first_cycle: assert property (
        @(posedge ref_clk) disable iff (reset)
        $past(reset) && ce |=> (state == sih_pkg::ST_START_LOW))
        else $error("no host cycle right after reset");

    // a device low clock counts as the first clock of the start pulse
    a_dev_takeover: assert property (
        @(posedge ref_clk) disable iff (reset || !ce)
        dev_start |=> (state == sih_pkg::ST_START_LOW) && (cnt == 4'h1))
        else $error("device start not taken over");

    // continuous mode: a low wire alone never starts a cycle
    a_cont_passive: assert property (
        @(posedge ref_clk) disable iff (reset || !ce)
        (state == sih_pkg::ST_IDLE) && !quiet_mode && !start_pending && !run_continuous
        |=> (state == sih_pkg::ST_IDLE))
        else $error("cycle started with nothing pending in continuous mode");

    a_mode_in_stop: assert property (
        @(posedge ref_clk) disable iff (reset || !ce)
        (state != sih_pkg::ST_STOP_LOW) |=> $stable(quiet_mode))
        else $error("mode changed outside the stop frame");

    a_level_sampled: assert property (
        @(posedge ref_clk) disable iff (reset || !ce)
        !(state == sih_pkg::ST_DATA && phase == sih_pkg::PH_SAMPLE)
        |=> $stable(irq_level))
        else $error("level captured outside a sample clock");

    a_eoi_held: assert property (
        @(posedge ref_clk) disable iff (reset || !ce)
        cycle_active |-> !eoi_grant)
        else $error("end-of-interrupt granted during a cycle");

endmodule : sih_host

// ---- testbench/sih_dev_model.sv ----
// device-side partner model of the serialized interrupt wire
`timescale 1ns/1ps
module sih_dev_model (
    // clock and reset
    input  wire logic           ref_clk,
    input  wire logic           reset,
    // shared interrupt wire
    input  wire logic           serial_interrupt_line,
    output sih_pkg::sih_drive_t dev_drv,
    // interrupt sources, bit 0 unused
    input  wire logic [15:0]    irq_src,
    input  wire logic           system_management_interrupt_n,
    input  wire logic           smi_en
);
    typedef enum logic [1:0] {DV_IDLE, DV_START, DV_DATA, DV_GAP} sih_dev_st_t;
    sih_dev_st_t st;
    logic [15:0] lvl;
    logic [5:0]  pos;
    logic [4:0]  frm;
    logic [1:0]  low_run;
    logic        quiet;
    logic        changed;
    logic        kick;
    logic        drove;
    logic        src;
    logic        samp_low;

    assign frm = 5'((pos + 6'h01) / 6'h03);
    // frame 3 shares management interrupt and line 2
    assign src = (frm == 5'h03 && smi_en) ? system_management_interrupt_n
                                          : lvl[4'(frm - 5'h01)];
    assign samp_low = st == DV_DATA && pos % 6'h03 == 6'h02 && frm >= 5'h02
                      && frm <= 5'h10 && !src;
    assign dev_drv.oe  = kick | samp_low | drove;
    assign dev_drv.out = drove;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st      <= DV_IDLE;
            quiet   <= 1'b0;
            kick    <= 1'b0;
            drove   <= 1'b0;
            changed <= 1'b0;
            pos     <= 6'h00;
            low_run <= 2'h0;
            lvl     <= 16'hFFFF;
        end else begin
            lvl   <= irq_src;
            drove <= samp_low;
            kick  <= 1'b0;
            if (lvl != irq_src) changed <= 1'b1;
            case (st)
                DV_IDLE: begin
                    if (!serial_interrupt_line) st <= DV_START;
                    else if (quiet && changed) kick <= 1'b1;
                end
                DV_START: begin
                    if (serial_interrupt_line) begin
                        st      <= DV_DATA;
                        pos     <= 6'h01;
                        changed <= 1'b0;
                    end
                end
                DV_DATA: begin
                    pos <= pos + 6'h01;
                    if (!serial_interrupt_line && pos > 6'h34) low_run <= low_run + 2'h1;
                    else if (low_run != 2'h0) begin
                        quiet   <= low_run == 2'h2;
                        low_run <= 2'h0;
                        st      <= DV_GAP;
                    end
                end
                default: st <= DV_IDLE;
            endcase
        end
    end
endmodule : sih_dev_model

// ---- testbench/sih_host_test.sv ----
// self-checking bench of the serial interrupt host controller
`timescale 1ns/1ps
module sih_host_test;
    logic ref_clk, reset, ce, start_req, run_continuous, quiet_sel, eoi_req;
    logic [3:0]  start_width;
    logic [15:0] irq_src, irq_level, exp;
    logic smi_n, smi_en, quiet_mode, cycle_active, cycle_done, eoi_grant, line;
    sih_pkg::sih_drive_t h_drv, d_drv;
    int errors = 0, samples_checked = 0, n, m, i, seed = 32'hb7dd;
    int run = 0, start_run = 0, last_run = 0;
    logic first = 1'b1;

    // wire pulled high when released
    assign line = (h_drv.oe ? h_drv.out : 1'b1) & (d_drv.oe ? d_drv.out : 1'b1);
    sih_host u_sih_host (.ref_clk(ref_clk), .reset(reset), .ce(ce),
        .serial_interrupt_line(line), .line_drv(h_drv), .start_req(start_req),
        .run_continuous(run_continuous), .quiet_sel(quiet_sel), .start_width(start_width),
        .irq_level(irq_level), .quiet_mode(quiet_mode), .cycle_active(cycle_active),
        .cycle_done(cycle_done), .eoi_req(eoi_req), .eoi_grant(eoi_grant));
    sih_dev_model u_sih_dev_model (.ref_clk(ref_clk), .reset(reset),
        .serial_interrupt_line(line), .dev_drv(d_drv), .irq_src(irq_src),
        .system_management_interrupt_n(smi_n), .smi_en(smi_en));

    always #50 ref_clk = ~ref_clk;
    // low-run widths: first run is the start pulse, last is the stop pulse
    always @(posedge ref_clk) begin
        if (!line) run <= run + 1;
        else if (run != 0) begin
            if (first) start_run <= run;
            last_run <= run;
            run      <= 0;
            first    <= 1'b0;
        end
        if (cycle_done === 1'b1) first <= 1'b1;
    end

    function automatic logic [15:0] exp_level();
        return {irq_src[15:3], smi_en ? smi_n : irq_src[2], irq_src[1], 1'b1};
    endfunction : exp_level
    task check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : check
    task tick;
        @(posedge ref_clk);
        #10;
    endtask : tick
    task wait_done(output int k);
        k = 0;
        do begin tick(); k++; end while (cycle_done !== 1'b1 && k < 400);
        if (k >= 400) errors++;
    endtask : wait_done
    task host_cycle(input logic [3:0] w, input logic q);
        irq_src = 16'($random(seed));
        smi_n = 1'($random(seed));
        smi_en = 1'($random(seed));
        start_width = w;
        quiet_sel = q;
        start_req = 1'b1;
        tick();
        start_req = 1'b0;
        wait_done(n);
        check(irq_level, exp_level());
        check(16'(start_run), (w < 4) ? 16'h4 : (w > 8) ? 16'h8 : 16'(w));
        check(16'(last_run), q ? 16'h2 : 16'h3);
        check(16'(quiet_mode), 16'(q));
        $display("cycle test done w=%0d q=%0d", w, q);
    endtask : host_cycle
    task tally_and_finish;
        $display("checks=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #1_000_000;
        errors++;
        tally_and_finish();
    end
    initial begin
        ref_clk = 0; reset = 1; ce = 1; start_req = 0; run_continuous = 0; quiet_sel = 0;
        start_width = 4'h4; eoi_req = 0; smi_n = 1; smi_en = 0;
        irq_src = 16'($random(seed));
        repeat (2) @(posedge ref_clk);
        #10;
        check(16'(h_drv.oe), 16'h0);
        check(irq_level, 16'hFFFF);
        check(16'(quiet_mode), 16'h0);
        reset = 0;
        wait_done(n);
        check(irq_level, exp_level());
        $display("reset test done");
        host_cycle(4'h0, 1'b1);
        host_cycle(4'hF, 1'b0);
        for (i = 0; i < 6; i++) host_cycle(4'(4 + $unsigned($random(seed)) % 5), 1'($random(seed)));
        // device-started cycle in quiet mode
        host_cycle(4'h6, 1'b1);
        eoi_req = 1;
        tick();
        tick();
        check(16'(eoi_grant), 16'h1);
        irq_src = ~irq_src;
        n = 0;
        while (cycle_active !== 1'b1 && n < 50) begin tick(); n++; end
        check(16'(eoi_grant), 16'h0);
        wait_done(m);
        eoi_req = 0;
        check(irq_level, exp_level());
        check(16'(start_run), 16'h6);
        check(16'(n + m <= sih_pkg::LATENCY_MAX), 16'h1);
        $display("device start test done");
        // continuous mode: device must stay passive
        host_cycle(4'h4, 1'b0);
        exp = exp_level();
        irq_src = ~irq_src;
        repeat (100) tick();
        check(irq_level, exp);
        $display("passive test done");
        // clock enable low freezes the wire drive
        start_req = 1;
        tick();
        start_req = 0;
        repeat (3) tick();
        ce = 0;
        tick();
        exp = 16'h0002;
        repeat (5) tick();
        check(16'(h_drv), exp);
        ce = 1;
        wait_done(n);
        // back-to-back continuous cycles
        run_continuous = 1;
        for (i = 0; i < 3; i++) begin
            wait_done(n);
            check(16'(n < 70), 16'h1);
        end
        run_continuous = 0;
        repeat (5) tick();
        check(16'(cycle_active), 16'h0);
        $display("continuous test done");
        tally_and_finish();
    end
endmodule : sih_host_test
